//--- inc/dta_pkg.sv
// Constants and types shared by the dual-target serial front end.
`default_nettype none
package dta_pkg;
  // ----------------------------------------------------------------
  // Address patterns and widths.
  // ----------------------------------------------------------------
  localparam int OPT_PINS = 6; // Number of optional address pins.
  localparam logic [5:0] REG_PATTERN = 6'h10; // Upper bits of the register target.
  localparam logic [5:0] MEM_PATTERN = 6'h28; // Upper bits of the memory target.
  localparam logic [2:0] ALL_PINS = 3'h6; // Pin count at which both targets merge.
  localparam int MEM_AW = 16; // Memory address width.
  localparam int PAGE_BITS = 6; // Program page is 64 bytes.
  localparam logic [3:0] BYTE_BITS = 4'h8; // Bits in one byte.
  localparam logic [1:0] WIDX_DATA = 2'h2; // Write byte index of the first memory data byte.
  localparam logic [7:0] FILL_BYTE = 8'hFF; // Returned when reading past the end.
  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_TX = 3'h6,
    ST_MACK = 3'h7
  } dta_state_t;
  typedef enum logic {
    TGT_REG = 1'b0,
    TGT_MEM = 1'b1
  } dta_tgt_t;
endpackage
`default_nettype wire

//--- inc/dta_line_if.sv
// Interface carrying bus line events from the line monitor to the core.
`default_nettype none
interface dta_line_if;
  logic rise; // Serial clock rose this cycle.
  logic fall; // Serial clock fell this cycle.
  logic start; // Start or repeated start seen.
  logic stop; // Stop seen.
  logic sda; // Current data level.
  modport mon (output rise, output fall, output start, output stop, output sda);
  modport ctl (input rise, input fall, input start, input stop, input sda);
endinterface
`default_nettype wire

//--- core/dta_line_mon.sv
// Line monitor turning clock and data levels into bus events.
`default_nettype none
module dta_line_mon (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic scl_i, // Serial clock level.
  input wire logic sda_i, // Serial data level.
  dta_line_if.mon lm // Events toward the core.
);
  logic scl_r;
  logic scl_nxt;
  logic sda_r;
  logic sda_nxt;
  // ----------------------------------------------------------------
  // Previous levels; idle bus is high, so reset high avoids a false edge.
  // ----------------------------------------------------------------
  always_comb begin
    scl_nxt = scl_i;
    sda_nxt = sda_i;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end
  // Data changing while the clock stays high marks start and stop.
  assign lm.rise = scl_i & ~scl_r;
  assign lm.fall = ~scl_i & scl_r;
  assign lm.start = scl_i & scl_r & sda_r & ~sda_i;
  assign lm.stop = scl_i & scl_r & ~sda_r & sda_i;
  assign lm.sda = sda_i;
endmodule // dta_line_mon
`default_nettype wire

//--- core/dta_core.sv
// Dual-target serial slave: address decode, pointers and memory access.
`default_nettype none
module dta_core #(
  parameter int unsigned MEM_SIZE = 32'h0000_1000 // Implemented memory bytes.
) (
  input wire logic clock, // System clock, 20 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic scl_i, // Serial clock level.
  output logic scl_o, // Clock drive value, always low.
  output logic scl_oe, // High while the clock is held low.
  input wire logic sda_i, // Serial data level.
  output logic sda_o, // Data drive value, always low.
  output logic sda_oe, // High while data is pulled low.
  input wire logic fixed_addr_pin, // Fixed lowest address bit.
  input wire logic [dta_pkg::OPT_PINS-1:0] optional_address_pins, // Extra address pins.
  input wire logic [2:0] addr_pin_count, // Extra pins in use, 0 to 6.
  input wire logic mem_write_block_pin, // High refuses memory writes.
  input wire logic mem_access_en, // Low blocks all memory access.
  output logic [dta_pkg::MEM_AW-1:0] mem_rd_addr, // Memory read address.
  input wire logic [7:0] mem_rd_data, // Data at mem_rd_addr, same cycle.
  output logic [dta_pkg::MEM_AW-1:0] mem_wr_addr, // Memory write address.
  output logic [7:0] wr_data, // Written byte for either target.
  output logic mem_we, // Memory write strobe.
  output logic mem_commit, // Page program start strobe.
  input wire logic mem_busy, // High while a page programs.
  output logic [7:0] reg_ptr, // Register pointer.
  input wire logic [7:0] reg_rd_data, // Register data at reg_ptr.
  output logic reg_we, // Register write strobe.
  output logic reg_re // Register read strobe.
);
  import dta_pkg::*;

  dta_line_if lm ();
  dta_state_t st_r, st_nxt;
  dta_tgt_t tgt_r, tgt_nxt, adr_tgt, rx_tgt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, wdat_r, wdat_nxt, ptr_r, ptr_nxt, ld_byte;
  logic [1:0] widx_r, widx_nxt;
  logic [MEM_AW-1:0] madr_r, madr_nxt, wadr_r, wadr_nxt, madr_inc;
  logic rw_r, rw_nxt, sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
  logic mwe_r, mwe_nxt, cmt_r, cmt_nxt, rwe_r, rwe_nxt, rre_r, rre_nxt;
  logic mnak_r, mnak_nxt, dirty_r, dirty_nxt;
  logic [6:0] reg_addr, mem_addr;
  logic shared, hit_reg, hit_mem, byte_end, in_range, do_load, adr_nak, rx_nak;

  dta_line_mon u_mon (
    .clock(clock),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .lm(lm.mon)
  );

  // ----------------------------------------------------------------
  // Target addresses: each extra pin takes over the next upper bit.
  // ----------------------------------------------------------------
  assign reg_addr[0] = fixed_addr_pin;
  assign mem_addr[0] = fixed_addr_pin;
  for (genvar i = 1; i <= OPT_PINS; i++) begin : g_abit
    assign reg_addr[i] = (addr_pin_count >= 3'(i)) ? optional_address_pins[i-1]
                                                    : REG_PATTERN[i-1];
    assign mem_addr[i] = (addr_pin_count >= 3'(i)) ? optional_address_pins[i-1]
                                                    : MEM_PATTERN[i-1];
  end

  // Decisions shared by the byte engine and the checks below.
  assign shared = (addr_pin_count == ALL_PINS);
  assign hit_reg = (sh_r[7:1] == reg_addr);
  assign hit_mem = (sh_r[7:1] == mem_addr);
  assign byte_end = lm.fall && (bit_r == BYTE_BITS);
  assign in_range = 32'(madr_r) < MEM_SIZE;
  assign madr_inc = madr_r + 16'h0001;
  assign adr_tgt = shared ? tgt_r : (hit_mem ? TGT_MEM : TGT_REG);
  // A shared write cannot know its target yet, so it is always taken.
  assign adr_nak = !(hit_reg || hit_mem)
                   || (adr_tgt == TGT_MEM && !(shared && !sh_r[0])
                       && (!mem_access_en || (sh_r[0] && !in_range)));
  assign rx_tgt = (widx_r == 2'h0 && shared) ? dta_tgt_t'(sh_r[7]) : tgt_r;
  assign rx_nak = rx_tgt == TGT_MEM
                  && (!mem_access_en
                      || (widx_r == WIDX_DATA && (mem_write_block_pin || !in_range)));
  assign do_load = lm.fall && ((st_r == ST_ACK && rw_r && !scl_oe_r)
                               || (st_r == ST_MACK && !mnak_r));
  // Past the end the master still clocks bytes, so a filler is sent.
  assign ld_byte = (tgt_r == TGT_REG) ? reg_rd_data : (in_range ? mem_rd_data : FILL_BYTE);

  // ----------------------------------------------------------------
  // Byte engine: next state.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    tgt_nxt = tgt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    wdat_nxt = wdat_r;
    ptr_nxt = ptr_r;
    widx_nxt = widx_r;
    madr_nxt = madr_r;
    wadr_nxt = wadr_r;
    rw_nxt = rw_r;
    sda_oe_nxt = sda_oe_r;
    scl_oe_nxt = scl_oe_r;
    mnak_nxt = mnak_r;
    dirty_nxt = dirty_r;
    mwe_nxt = 1'b0;
    cmt_nxt = 1'b0;
    rwe_nxt = 1'b0;
    rre_nxt = 1'b0;
    if (lm.stop) begin
      st_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
      // A partial page is programmed at the stop; nothing is left to stretch.
      if (dirty_r) begin
        cmt_nxt = 1'b1;
        dirty_nxt = 1'b0;
      end
    end else if (lm.start) begin
      st_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      widx_nxt = 2'h0;
      sda_oe_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_RX: begin
          if (lm.rise && bit_r != BYTE_BITS) begin
            sh_nxt = {sh_r[6:0], lm.sda};
            bit_nxt = bit_r + 4'h1;
          end else if (byte_end && st_r == ST_ADDR) begin
            if (adr_nak) begin
              st_nxt = ST_IDLE;
            end else begin
              st_nxt = ST_ACK;
              sda_oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
              tgt_nxt = adr_tgt;
            end
          end else if (byte_end) begin
            tgt_nxt = rx_tgt;
            if (rx_nak) begin
              st_nxt = ST_IDLE;
            end else begin
              st_nxt = ST_ACK;
              sda_oe_nxt = 1'b1;
              if (widx_r != WIDX_DATA) begin
                widx_nxt = widx_r + 2'h1;
              end
              if (rx_tgt == TGT_REG) begin
                if (widx_r == 2'h0) begin
                  ptr_nxt = sh_r;
                end else begin
                  rwe_nxt = 1'b1;
                  wdat_nxt = sh_r;
                end
              end else if (widx_r == 2'h0) begin
                madr_nxt[15:8] = {sh_r[7] & ~shared, sh_r[6:0]};
              end else if (widx_r == 2'h1) begin
                madr_nxt[7:0] = sh_r;
              end else begin
                mwe_nxt = 1'b1;
                wadr_nxt = madr_r;
                wdat_nxt = sh_r;
                madr_nxt = madr_inc;
                dirty_nxt = 1'b1;
                // Crossing a page programs it; the clock is held meanwhile.
                if (madr_inc[PAGE_BITS-1:0] == '0) begin
                  cmt_nxt = 1'b1;
                  scl_oe_nxt = 1'b1;
                  dirty_nxt = 1'b0;
                end
              end
            end
          end
        end
        ST_ACK: begin
          if (lm.fall && !scl_oe_r) begin
            sda_oe_nxt = 1'b0;
            bit_nxt = 4'h0;
            st_nxt = rw_r ? ST_TX : ST_RX;
          end
        end
        ST_TX: begin
          if (lm.fall && bit_r == BYTE_BITS) begin
            sda_oe_nxt = 1'b0;
            st_nxt = ST_MACK;
          end else if (lm.fall) begin
            sda_oe_nxt = ~sh_r[7];
            sh_nxt = {sh_r[6:0], 1'b0};
            bit_nxt = bit_r + 4'h1;
          end
        end
        ST_MACK: begin
          if (lm.rise) begin
            mnak_nxt = lm.sda;
          end else if (lm.fall) begin
            st_nxt = mnak_r ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
      // First bit of a read byte goes out on the same fall that ends the ack.
      if (do_load) begin
        sda_oe_nxt = ~ld_byte[7];
        sh_nxt = {ld_byte[6:0], 1'b0};
        bit_nxt = 4'h1;
        mnak_nxt = 1'b0;
        if (tgt_r == TGT_REG) begin
          rre_nxt = 1'b1;
        end else if (in_range) begin
          madr_nxt = madr_inc;
        end
      end
    end
    // The clock is let go once the program pulse is gone and busy is low.
    if (scl_oe_r && !cmt_r && !mem_busy) begin
      scl_oe_nxt = 1'b0;
    end
  end

  // Byte engine: registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      tgt_r <= TGT_REG;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      wdat_r <= 8'h00;
      ptr_r <= 8'h00;
      widx_r <= 2'h0;
      madr_r <= 16'h0000;
      wadr_r <= 16'h0000;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      mnak_r <= 1'b0;
      dirty_r <= 1'b0;
      mwe_r <= 1'b0;
      cmt_r <= 1'b0;
      rwe_r <= 1'b0;
      rre_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tgt_r <= tgt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      wdat_r <= wdat_nxt;
      ptr_r <= ptr_nxt;
      widx_r <= widx_nxt;
      madr_r <= madr_nxt;
      wadr_r <= wadr_nxt;
      rw_r <= rw_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_oe_r <= scl_oe_nxt;
      mnak_r <= mnak_nxt;
      dirty_r <= dirty_nxt;
      mwe_r <= mwe_nxt;
      cmt_r <= cmt_nxt;
      rwe_r <= rwe_nxt;
      rre_r <= rre_nxt;
    end
  end

  // Open-drain pins only ever pull low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign mem_rd_addr = madr_r;
  assign mem_wr_addr = wadr_r;
  assign wr_data = wdat_r;
  assign mem_we = mwe_r;
  assign mem_commit = cmt_r;
  assign reg_ptr = ptr_r;
  assign reg_we = rwe_r;
  assign reg_re = rre_r;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_addr_end;
    st_r == ST_ADDR && byte_end;
  endsequence
  sequence s_rx_end;
    st_r == ST_RX && byte_end;
  endsequence
  property p_base_addr;
    s_addr_end ##0 (addr_pin_count == 3'h0 && sh_r[7:1] == {REG_PATTERN, fixed_addr_pin})
      |=> st_r == ST_ACK && sda_oe_r;
  endproperty
  a_base_addr: assert property (p_base_addr)
    else $error("Default register target address not acknowledged.");
  property p_pin_addr;
    s_addr_end ##0 (shared && !sh_r[0] && sh_r[7:1] == {optional_address_pins, fixed_addr_pin})
      |=> st_r == ST_ACK;
  endproperty
  a_pin_addr: assert property (p_pin_addr)
    else $error("Pin-defined address not acknowledged.");
  property p_cmd_ptr;
    s_rx_end ##0 (shared && widx_r == 2'h0 && !sh_r[7]) |=> tgt_r == TGT_REG && ptr_r == $past(sh_r);
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr)
    else $error("First byte with low top bit not taken as pointer.");
  property p_mem_high;
    s_rx_end ##0 (shared && widx_r == 2'h0 && sh_r[7] && mem_access_en)
      |=> madr_r[15:8] == (8'h7F & $past(sh_r));
  endproperty
  a_mem_high: assert property (p_mem_high)
    else $error("Masked high memory address byte wrong.");
  property p_mem_low;
    s_rx_end ##0 (tgt_r == TGT_MEM && widx_r == 2'h1 && mem_access_en) |=> madr_r[7:0] == $past(sh_r);
  endproperty
  a_mem_low: assert property (p_mem_low)
    else $error("Low memory address byte not stored.");
  property p_rd_inc;
    do_load && tgt_r == TGT_MEM && in_range |=> madr_r == $past(madr_inc) ##1 st_r == ST_TX;
  endproperty
  a_rd_inc: assert property (p_rd_inc)
    else $error("Read address did not advance by one.");
  property p_end_nak;
    s_rx_end ##0 (tgt_r == TGT_MEM && widx_r == WIDX_DATA && !in_range) |=> !sda_oe_r && !mwe_r;
  endproperty
  a_end_nak: assert property (p_end_nak)
    else $error("Write past the end was acknowledged.");
  property p_stretch;
    cmt_r && st_r == ST_ACK |-> scl_oe_r ##1 scl_oe_r;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Clock not held while a page programs.");
  property p_block;
    s_rx_end ##0 (tgt_r == TGT_MEM && widx_r == WIDX_DATA && mem_write_block_pin)
      |=> !mwe_r && st_r == ST_IDLE;
  endproperty
  a_block: assert property (p_block)
    else $error("Memory write taken while blocked.");
  property p_mem_off;
    s_addr_end ##0 (!shared && !mem_access_en && hit_mem && !hit_reg) |=> st_r == ST_IDLE;
  endproperty
  a_mem_off: assert property (p_mem_off)
    else $error("Memory target answered while disabled.");
  property p_seq_wr;
    mwe_r |-> madr_r == wadr_r + 16'h0001;
  endproperty
  a_seq_wr: assert property (p_seq_wr)
    else $error("Next write address is not sequential.");
endmodule // dta_core
`default_nettype wire

//--- bench/dta_bus_master.sv
// Serial bus master model that waits out clock stretching.
`default_nettype none
module dta_bus_master #(
  parameter int Q = 4 // System clocks per quarter bit.
) (
  input wire logic clock, // System clock.
  input wire logic scl, // Resolved clock line.
  input wire logic sda, // Resolved data line.
  output logic scl_oe, // High pulls the clock line low.
  output logic sda_oe // High pulls the data line low.
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Bit and byte tasks.
  // -------------------------------------------------------------
  // Both lines start released so the pull-ups hold them high.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic qtr();
    repeat (Q) @(posedge clock);
  endtask
  // Releasing is not enough: the slave may hold the clock low, so wait for the line.
  task automatic rel_scl();
    @(posedge clock);
    scl_oe <= 1'b0;
    for (int n = 0; n < 4000 && scl !== 1'b1; n++) @(posedge clock);
    qtr();
  endtask
  // One bit: data set while the clock is low, line sampled at the end of the high phase.
  task automatic bit_out(input logic b, output logic s);
    @(posedge clock);
    sda_oe <= ~b;
    qtr();
    rel_scl();
    s = sda;
    @(posedge clock);
    scl_oe <= 1'b1;
    qtr();
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    @(posedge clock);
    sda_oe <= 1'b0;
    qtr();
    rel_scl();
    @(posedge clock);
    sda_oe <= 1'b1;
    qtr();
    @(posedge clock);
    scl_oe <= 1'b1;
    qtr();
  endtask
  // Stop: data rises while the clock is high, then both lines stay released.
  task automatic stop();
    @(posedge clock);
    sda_oe <= 1'b1;
    qtr();
    rel_scl();
    @(posedge clock);
    sda_oe <= 1'b0;
    qtr();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(d[i], s);
    bit_out(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // A last byte is refused with a high acknowledge bit to end the read.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(1'b1, d[i]);
    bit_out(last, s);
  endtask
endmodule // dta_bus_master
`default_nettype wire

//--- bench/i2c_dual_target_addr_eeprom_access_test.sv
// Self-checking bench for the dual-target serial slave, with memory and register models.
`default_nettype none
module i2c_dual_target_addr_eeprom_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dta_pkg::*;
  localparam int unsigned MSZ = 32'h0000_0050; // Small memory so its end is reachable.
  logic clock, rst_n, m_scl_oe, m_sda_oe, scl_oe, sda_oe, scl, sda, fixed_addr_pin;
  logic mem_write_block_pin, mem_access_en, mem_we, mem_commit, mem_busy, reg_we;
  logic reg_re, scl_o, sda_o;
  logic [5:0] opt_pins;
  logic [2:0] pin_cnt;
  logic [15:0] mem_rd_addr, mem_wr_addr;
  logic [7:0] mem_rd_data, wr_data, reg_ptr, reg_rd_data;
  logic [7:0] mem [0:255];
  logic [7:0] shadow [0:255];
  logic [7:0] regs [0:255];
  int fails, comparisons, cycles, busy_cnt, stretch_cnt, rre_cnt;
  // -------------------------------------------------------------
  // Lines, models and clock.
  // -------------------------------------------------------------
  // Open-drain lines with pull-ups: low while any party pulls.
  assign scl = ~(m_scl_oe | scl_oe);
  assign sda = ~(m_sda_oe | sda_oe);
  assign mem_rd_data = mem[mem_rd_addr[7:0]];
  assign reg_rd_data = regs[reg_ptr];
  assign mem_busy = (busy_cnt != 0);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  dta_core #(.MEM_SIZE(MSZ)) dta_core_inst (.clock(clock), .rst_n(rst_n), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .fixed_addr_pin(fixed_addr_pin), .optional_address_pins(opt_pins),
    .addr_pin_count(pin_cnt), .mem_write_block_pin(mem_write_block_pin),
    .mem_access_en(mem_access_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_addr(mem_wr_addr), .wr_data(wr_data), .mem_we(mem_we), .mem_commit(mem_commit),
    .mem_busy(mem_busy), .reg_ptr(reg_ptr), .reg_rd_data(reg_rd_data), .reg_we(reg_we),
    .reg_re(reg_re));
  dta_bus_master dta_bus_master_inst (.clock(clock), .scl(scl), .sda(sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  // Storage models; a random programming time exercises stretching of varying length.
  always @(posedge clock) begin
    if (mem_we)
      mem[mem_wr_addr[7:0]] <= wr_data;
    if (reg_we)
      regs[reg_ptr] <= wr_data;
    if (mem_commit)
      busy_cnt <= 3 + ($urandom % 40);
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
    if (scl_oe)
      stretch_cnt <= stretch_cnt + 1;
    if (reg_re)
      rre_cnt <= rre_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails++;
      $display("[ERR] %0t run timed out", $time);
      complete_run();
    end
  end
  // -------------------------------------------------------------
  // Checking and transfer tasks.
  // -------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Expected target address from the pin count, pins and fixed bit.
  function automatic logic [6:0] dev_addr(input logic tm, input logic [2:0] c,
      input logic [5:0] p, input logic a0);
    logic [5:0] pat;
    pat = tm ? MEM_PATTERN : REG_PATTERN;
    for (int i = 0; i < 6; i++) if (i < c) pat[i] = p[i];
    return {pat, a0};
  endfunction
  task automatic send(input logic [7:0] b, input logic exp, input string msg);
    logic ack;
    dta_bus_master_inst.wr_byte(b, ack);
    check(ack === exp, msg);
  endtask
  // Address, high and low bytes, then data in one transfer; stops at the first refusal.
  task automatic mem_wr(input logic [6:0] dev, input logic [15:0] a, input int n,
      input logic sh);
    logic [7:0] d;
    logic ok;
    dta_bus_master_inst.start();
    send({dev, 1'b0}, mem_access_en, "memory address ack");
    if (mem_access_en) begin
      send(a[15:8] | {sh, 7'h00}, 1'b1, "high byte ack");
      send(a[7:0], 1'b1, "low byte ack");
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        ok = (a + i < MSZ) && !mem_write_block_pin;
        send(d, ok, "data byte ack");
        if (!ok)
          break;
        shadow[a + i] = d;
      end
    end
    dta_bus_master_inst.stop();
    repeat (3) @(posedge clock);
    for (int k = 0; k < 200 && mem_busy; k++) @(posedge clock);
  endtask
  // Address write first, then a repeated start for the read.
  task automatic mem_rd(input logic [6:0] dev, input logic [15:0] a, input int n,
      input logic sh);
    logic [7:0] d;
    dta_bus_master_inst.start();
    send({dev, 1'b0}, mem_access_en, "memory address ack");
    if (mem_access_en) begin
      send(a[15:8] | {sh, 7'h00}, 1'b1, "high byte ack");
      send(a[7:0], 1'b1, "low byte ack");
      dta_bus_master_inst.start();
      send({dev, 1'b1}, a < MSZ, "read address ack");
      for (int i = 0; i < n && a < MSZ; i++) begin
        dta_bus_master_inst.rd_byte(i == n - 1, d);
        check(d === ((a + i < MSZ) ? shadow[a + i] : FILL_BYTE), "read data");
      end
    end
    dta_bus_master_inst.stop();
  endtask
  // Pointer then data, then read back through the same pointer.
  task automatic reg_acc(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    int r0;
    dta_bus_master_inst.start();
    send({dev, 1'b0}, 1'b1, "register address ack");
    send(p, 1'b1, "pointer ack");
    send(d, 1'b1, "register data ack");
    dta_bus_master_inst.stop();
    check(regs[p] === d, "register write");
    dta_bus_master_inst.start();
    send({dev, 1'b0}, 1'b1, "register address ack");
    send(p, 1'b1, "pointer ack");
    // The read strobe comes with the address acknowledge, so count from before it.
    r0 = rre_cnt;
    dta_bus_master_inst.start();
    send({dev, 1'b1}, 1'b1, "register read ack");
    dta_bus_master_inst.rd_byte(1'b1, r);
    dta_bus_master_inst.stop();
    check(r === d, "register read");
    check(rre_cnt == r0 + 1, "one register read strobe");
  endtask
  // -------------------------------------------------------------
  // Test sequence.
  // -------------------------------------------------------------
  initial begin
    logic [6:0] rd, md;
    logic [15:0] a;
    int n, s0;
    void'($urandom(51));
    {rst_n, fixed_addr_pin, opt_pins, pin_cnt, mem_write_block_pin} <= '0;
    mem_access_en <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      shadow[i] = mem[i];
      regs[i] = 8'h00;
    end
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(scl_oe === 1'b0 && sda_oe === 1'b0, "lines released after reset");
    check(scl_o === 1'b0 && sda_o === 1'b0, "open-drain drive values low");
    repeat (2) @(posedge clock);
    // Every pin count; count six merges both targets and selects by the first byte.
    for (int c = 0; c < 7; c++) begin
      @(posedge clock);
      pin_cnt <= 3'(c);
      opt_pins <= 6'($urandom);
      fixed_addr_pin <= 1'($urandom);
      @(posedge clock);
      rd = dev_addr(1'b0, pin_cnt, opt_pins, fixed_addr_pin);
      md = dev_addr(1'b1, pin_cnt, opt_pins, fixed_addr_pin);
      reg_acc(rd, 8'($urandom) & 8'h7F, 8'($urandom));
      dta_bus_master_inst.start();
      send({rd ^ 7'h01, 1'b0}, 1'b0, "foreign address refused");
      dta_bus_master_inst.stop();
      a = 16'($urandom % (MSZ - 8));
      mem_wr(md, a, 2, c == 6);
      mem_rd(md, a, 2, c == 6);
    end
    $display("test address decode done");
    @(posedge clock);
    {pin_cnt, opt_pins, fixed_addr_pin} <= '0;
    md = {MEM_PATTERN, 1'b0};
    // Random block writes at random start addresses, each read back in one burst.
    for (int k = 0; k < 6; k++) begin
      a = 16'($urandom % (MSZ - 8));
      n = 1 + ($urandom % 8);
      mem_wr(md, a, n, 1'b0);
      mem_rd(md, a, n, 1'b0);
    end
    $display("test random blocks done");
    // An unaligned start that crosses a page must stretch; a partial page must not.
    s0 = stretch_cnt;
    mem_wr(md, 16'h003E, 4, 1'b0);
    check(stretch_cnt != s0, "clock held during page program");
    s0 = stretch_cnt;
    mem_wr(md, 16'h0041, 2, 1'b0);
    check(stretch_cnt == s0, "no hold inside a page");
    mem_rd(md, 16'h003E, 6, 1'b0);
    $display("test page crossing done");
    // Writes and reads running off the end of memory.
    mem_wr(md, 16'h004E, 3, 1'b0);
    mem_rd(md, 16'h004E, 3, 1'b0);
    mem_rd(md, 16'h0050, 1, 1'b0);
    $display("test memory end done");
    @(posedge clock);
    mem_write_block_pin <= 1'b1;
    mem_wr(md, 16'h0010, 2, 1'b0);
    @(posedge clock);
    mem_write_block_pin <= 1'b0;
    mem_rd(md, 16'h0010, 2, 1'b0);
    @(posedge clock);
    mem_access_en <= 1'b0;
    mem_wr(md, 16'h0020, 1, 1'b0);
    mem_rd(md, 16'h0020, 1, 1'b0);
    @(posedge clock);
    mem_access_en <= 1'b1;
    mem_rd(md, 16'h0020, 1, 1'b0);
    $display("test write block and disable done");
    complete_run();
  end
endmodule // i2c_dual_target_addr_eeprom_access_test
`default_nettype wire
